// >>> rtl/ccsos_top.v
// clock source selection, delay taps and output steering around the loop
//
// How it works
// - three global outputs, each from its own global multiplexer.
// - core-local twins follow secondary outputs with extra selectable delay.
// - core-local outputs go to local logic, no global resource.
// - enables only primary, primary+sec1 group, or primary+sec1+sec2 groups.
// - every one of five outputs has its own delay tap.
// - feedback delay advances all outputs against the reference.
// - static reference during power-up makes outputs toggle free.
// - sleep asserted disables loop, all outputs low.
// - source is single-ended pad, differential pair, routed regular pad, or core logic.
// - one single-ended pad is chosen; the others stay user pads.
// - pads one and two pair; pad three pairs with a regular pad.
// - a mux tree picks pad input or fabric clock.
// - pads not feeding a clock remain usable as user pads.
// - delay-only path may use any of nine pads.
// - loop in use accepts hardwired pads of primary mux only.
// - reference from hardwired pad, routed regular pad, or core logic.
// - routed or core reference takes an extra routing stage.
// - lock rises once reference and feedback stay aligned.
`timescale 1ns/1ps
`include "ccsos_map.vh"

module ccsos_top #(
    parameter DLY_W = 4,
    parameter LOCK_EDGES = `CCSOS_LOCK_EDGES
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // global pads, three per multiplexer, mux n at [3n+2:3n]
    input wire [8:0] glob_pad_i,
    // regular pads completing the second differential pair per mux
    input wire [2:0] pair_reg_n_i,
    // regular pad reaching the block through fabric routing
    input wire routed_ref_i,
    // clock made by core logic
    input wire core_clk_i,
    // outside feedback and sleep control
    input wire outside_feedback_in_i,
    input wire loop_sleep_n_i,
    // static configuration, caught while rst_i is high
    input wire [1:0] cfg_src_i,
    input wire [1:0] cfg_mux_i,
    input wire [1:0] cfg_pad_i,
    input wire cfg_diff_i,
    input wire cfg_pair_i,
    input wire cfg_loop_used_i,
    input wire cfg_ext_fb_i,
    input wire [4:0] cfg_out_en_i,
    input wire [5*DLY_W-1:0] cfg_dly_i,
    input wire [DLY_W-1:0] cfg_fb_adv_i,
    // derived clocks
    output reg primary_global_clk_out_o,
    output reg secondary1_global_clk_out_o,
    output reg secondary2_global_clk_out_o,
    output reg core1_local_clk_out_o,
    output reg core2_local_clk_out_o,
    // status
    output reg lock_o,
    output reg cfg_err_o,
    output reg [8:0] pad_user_o
);

    localparam NSYNC = 16;
    localparam TAP_W = 6;

    // configuration registers
    reg [1:0] src_q;
    reg [1:0] mux_q;
    reg [1:0] pad_q;
    reg diff_q;
    reg pair_q;
    reg loop_q;
    reg ext_fb_q;
    reg [4:0] en_q;
    reg [5*DLY_W-1:0] dly_q;
    reg [DLY_W-1:0] adv_q;

    // settings never move while running; reloaded only during reset
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            src_q <= cfg_src_i;
            mux_q <= cfg_mux_i;
            pad_q <= cfg_pad_i;
            diff_q <= cfg_diff_i;
            pair_q <= cfg_pair_i;
            loop_q <= cfg_loop_used_i;
            ext_fb_q <= cfg_ext_fb_i;
            en_q <= cfg_out_en_i;
            dly_q <= cfg_dly_i;
            adv_q <= cfg_fb_adv_i;
        end
    end

    // two-flop synchronisers for every pin-level input
    reg [NSYNC-1:0] sync1_q;
    reg [NSYNC-1:0] sync2_q;
    wire [NSYNC-1:0] raw_in;
    assign raw_in = {loop_sleep_n_i, outside_feedback_in_i, core_clk_i, routed_ref_i, pair_reg_n_i, glob_pad_i};

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    wire awake;
    wire fb_pin;
    assign awake = sync2_q[15];
    assign fb_pin = sync2_q[14];

    // per-mux pad trio and its regular partner
    reg [2:0] trio;
    reg pair_n;
    reg se_clk;
    reg pad_clk;

    always @* begin
        case (mux_q)
            2'h0: begin
                trio = sync2_q[2:0];
                pair_n = sync2_q[9];
            end
            2'h1: begin
                trio = sync2_q[5:3];
                pair_n = sync2_q[10];
            end
            default: begin
                trio = sync2_q[8:6];
                pair_n = sync2_q[11];
            end
        endcase
        case (pad_q)
            2'h1: se_clk = trio[1];
            2'h2: se_clk = trio[2];
            default: se_clk = trio[0];
        endcase
        // differential level taken as p high and n low
        if (diff_q) begin
            pad_clk = pair_q ? (trio[2] & ~pair_n) : (trio[0] & ~trio[1]);
        end else begin
            pad_clk = se_clk;
        end
    end

    // routed and core clocks pay one extra stage over the hardwired pads
    reg route_q;
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            route_q <= 1'b0;
        end else begin
            route_q <= (src_q == `CCSOS_SRC_ROUTED) ? sync2_q[12] : sync2_q[13];
        end
    end

    wire ref_clk;
    assign ref_clk = (src_q == `CCSOS_SRC_PAD) ? pad_clk : route_q;

    // illegal groupings or a foreign pad feeding the loop
    wire grp_bad;
    wire pad_bad;
    wire sec1_any;
    wire sec2_any;
    assign sec1_any = en_q[`CCSOS_OUT_GLB] | en_q[`CCSOS_OUT_YB];
    assign sec2_any = en_q[`CCSOS_OUT_GLC] | en_q[`CCSOS_OUT_YC];
    assign grp_bad = ~en_q[`CCSOS_OUT_GLA] | (sec2_any & ~sec1_any);
    assign pad_bad = loop_q & (src_q == `CCSOS_SRC_PAD) & (mux_q != 2'h0);
    wire cfg_bad;
    assign cfg_bad = grp_bad | pad_bad | (src_q == 2'h3) | (mux_q == 2'h3) | (pad_q == 2'h3);

    // reference edge watch; a quiet reference lets the oscillator run free
    reg ref_prev_q;
    reg [15:0] quiet_q;
    reg osc_q;
    wire ref_rise;
    wire stale;
    assign ref_rise = ref_clk & ~ref_prev_q;
    assign stale = (quiet_q >= `CCSOS_STATIC_CYC);

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ref_prev_q <= 1'b0;
            quiet_q <= 16'h0000;
            osc_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_clk;
            if (ref_clk != ref_prev_q) begin
                quiet_q <= 16'h0000;
            end else if (!stale) begin
                quiet_q <= quiet_q + 16'h0001;
            end
            // half the system rate stands in for the 40..250 MHz gear
            osc_q <= stale & ~osc_q;
        end
    end

    // loop source: delay-only path passes the reference straight on
    wire loop_src;
    assign loop_src = (loop_q & stale) ? osc_q : ref_clk;

    // shared delay line; each output picks its own tap
    reg [`CCSOS_LINE_LEN-1:0] line_q;
    always @(posedge sys_clk_i) begin
        if (rst_i || !awake) begin
            line_q <= 32'h00000000;
        end else begin
            line_q <= {line_q[`CCSOS_LINE_LEN-2:0], loop_src};
        end
    end

    wire [4:0] tap_val;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_tap
            wire [TAP_W-1:0] base;
            wire [TAP_W-1:0] adv;
            wire [TAP_W-1:0] tap;
            // core twins reach further down the line
            assign base = {{(TAP_W-DLY_W){1'b0}}, dly_q[gi*DLY_W +: DLY_W]} +
                ((gi == `CCSOS_OUT_YB || gi == `CCSOS_OUT_YC) ? `CCSOS_CORE_EXTRA : 6'h00);
            assign adv = loop_q ? {{(TAP_W-DLY_W){1'b0}}, adv_q} : 6'h00;
            assign tap = (adv > base) ? 6'h00 : (base - adv);
            assign tap_val[gi] = line_q[tap[4:0]];
        end
    endgenerate

    // outputs: own flop per global mux and per core-local twin
    wire run;
    assign run = awake & ~cfg_bad;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            primary_global_clk_out_o <= 1'b0;
            secondary1_global_clk_out_o <= 1'b0;
            secondary2_global_clk_out_o <= 1'b0;
            core1_local_clk_out_o <= 1'b0;
            core2_local_clk_out_o <= 1'b0;
            cfg_err_o <= 1'b0;
        end else begin
            primary_global_clk_out_o <= run & en_q[`CCSOS_OUT_GLA] & tap_val[`CCSOS_OUT_GLA];
            secondary1_global_clk_out_o <= run & en_q[`CCSOS_OUT_GLB] & tap_val[`CCSOS_OUT_GLB];
            secondary2_global_clk_out_o <= run & en_q[`CCSOS_OUT_GLC] & tap_val[`CCSOS_OUT_GLC];
            // local twins never touch a global network
            core1_local_clk_out_o <= run & en_q[`CCSOS_OUT_YB] & tap_val[`CCSOS_OUT_YB];
            core2_local_clk_out_o <= run & en_q[`CCSOS_OUT_YC] & tap_val[`CCSOS_OUT_YC];
            cfg_err_o <= cfg_bad;
        end
    end

    // feedback compare: internal uses the primary tap, else the pin
    wire fb_clk;
    assign fb_clk = ext_fb_q ? fb_pin : tap_val[`CCSOS_OUT_GLA];
    reg fb_prev_q;
    reg fb_seen_q;
    reg [7:0] lock_cnt_q;
    wire fb_rise;
    wire lock_ok;
    assign fb_rise = fb_clk & ~fb_prev_q;
    assign lock_ok = loop_q & run & ~stale;

    // a feedback edge in the same cycle as the reference edge still counts
    always @(posedge sys_clk_i) begin
        if (rst_i || !lock_ok) begin
            fb_prev_q <= 1'b0;
            fb_seen_q <= 1'b0;
            lock_cnt_q <= 8'h00;
            lock_o <= 1'b0;
        end else begin
            fb_prev_q <= fb_clk;
            if (ref_rise) begin
                fb_seen_q <= 1'b0;
                if (fb_seen_q | fb_rise) begin
                    if (lock_cnt_q != LOCK_EDGES[7:0]) begin
                        lock_cnt_q <= lock_cnt_q + 8'h01;
                    end
                end else begin
                    lock_cnt_q <= 8'h00;
                end
            end else if (fb_rise) begin
                fb_seen_q <= 1'b1;
            end
            lock_o <= (lock_cnt_q == LOCK_EDGES[7:0]);
        end
    end

    // pads not carrying the clock are handed back as user pads
    reg [2:0] used_trio;
    reg [8:0] used_pads;
    always @* begin
        if (diff_q) begin
            used_trio = pair_q ? 3'h4 : 3'h3;
        end else begin
            case (pad_q)
                2'h1: used_trio = 3'h2;
                2'h2: used_trio = 3'h4;
                default: used_trio = 3'h1;
            endcase
        end
        case (mux_q)
            2'h0: used_pads = {6'h00, used_trio};
            2'h1: used_pads = {3'h0, used_trio, 3'h0};
            default: used_pads = {used_trio, 6'h00};
        endcase
        if (src_q != `CCSOS_SRC_PAD) begin
            used_pads = 9'h000;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pad_user_o <= 9'h1ff;
        end else begin
            pad_user_o <= ~used_pads;
        end
    end

endmodule

// >>> rtl/ccsos_map.vh
// constants for the clock source and output select block
`ifndef CCSOS_MAP_VH
`define CCSOS_MAP_VH
// reference source choices
`define CCSOS_SRC_PAD 2'h0
`define CCSOS_SRC_ROUTED 2'h1
`define CCSOS_SRC_CORE 2'h2
// bit positions inside the output enable vector
`define CCSOS_OUT_GLA 0
`define CCSOS_OUT_GLB 1
`define CCSOS_OUT_YB 2
`define CCSOS_OUT_GLC 3
`define CCSOS_OUT_YC 4
// delay line shape
`define CCSOS_LINE_LEN 32
`define CCSOS_CORE_EXTRA 6'h10
// free-running gear range of the oscillator
`define CCSOS_GEAR_MIN_MHZ 40
`define CCSOS_GEAR_MAX_MHZ 250
// timing
`define CCSOS_SYS_MHZ 50
`define CCSOS_STATIC_NS 1000
`define CCSOS_STATIC_CYC ((`CCSOS_STATIC_NS * `CCSOS_SYS_MHZ) / 1000)
`define CCSOS_LOCK_EDGES 8
`endif

// >>> verif/ccsos_top_properties.sv
// assertion checker for the clock source and output select block
`timescale 1ns/1ps
module ccsos_top_properties #(
    parameter DLY_W = 4
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [8:0] glob_pad_i,
    input wire loop_sleep_n_i,
    input wire [1:0] cfg_src_i,
    input wire [1:0] cfg_mux_i,
    input wire [1:0] cfg_pad_i,
    input wire cfg_diff_i,
    input wire cfg_loop_used_i,
    input wire [4:0] cfg_out_en_i,
    input wire [5*DLY_W-1:0] cfg_dly_i,
    input wire primary_global_clk_out_o,
    input wire secondary1_global_clk_out_o,
    input wire secondary2_global_clk_out_o,
    input wire core1_local_clk_out_o,
    input wire core2_local_clk_out_o,
    input wire lock_o,
    input wire cfg_err_o,
    input wire [8:0] pad_user_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // all five derived clocks folded together
    wire [4:0] outs = {primary_global_clk_out_o, secondary1_global_clk_out_o,
        secondary2_global_clk_out_o, core1_local_clk_out_o, core2_local_clk_out_o};
    // sleep is asynchronous, so allow the synchroniser to settle first
    a_sleep_quiet: assert property (!loop_sleep_n_i [*4] |-> outs == 5'h00 && !lock_o)
        else $error("outputs active while asleep");
    a_err_quiet: assert property (cfg_err_o |-> outs == 5'h00 && !lock_o)
        else $error("outputs active with bad config");
    a_gla_needed: assert property (!$past(rst_i) && !cfg_out_en_i[0] |-> cfg_err_o)
        else $error("primary off not refused");
    a_group_order: assert property (!$past(rst_i) && cfg_out_en_i[2:1] == 2'h0 &&
        cfg_out_en_i[4:3] != 2'h0 |-> cfg_err_o)
        else $error("third group without second not refused");
    a_loop_mux: assert property (!$past(rst_i) && cfg_loop_used_i && cfg_src_i == 2'h0 &&
        cfg_mux_i != 2'h0 |-> cfg_err_o)
        else $error("loop on non-primary pad not refused");
    // the first edge after release still loads the caught config, so skip two
    a_cfg_static: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
        $stable(cfg_err_o) && $stable(pad_user_o))
        else $error("static config changed at run time");
    // sleep reaches the lock logic through two flops, three ticks before the rise is seen
    a_lock_cause: assert property ($rose(lock_o) |-> !cfg_err_o && $past(loop_sleep_n_i, 3))
        else $error("lock rose without a running loop");
    // hardwired pad 0 through a zero tap shows up four edges later
    a_pad_path: assert property (loop_sleep_n_i [*5] ##0 (!$past(rst_i, 5) && !cfg_err_o &&
        cfg_src_i == 2'h0 && cfg_mux_i == 2'h0 && cfg_pad_i == 2'h0 && !cfg_diff_i &&
        !cfg_loop_used_i && cfg_dly_i[DLY_W-1:0] == 0) |->
        primary_global_clk_out_o == $past(glob_pad_i[0], 4))
        else $error("primary does not follow pad");
    c_lock: cover property ($rose(lock_o));
    c_err: cover property ($rose(cfg_err_o));
    c_sleep: cover property ($fell(loop_sleep_n_i));
endmodule
bind ccsos_top ccsos_top_properties #(.DLY_W(DLY_W)) i_ccsos_top_properties (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .glob_pad_i(glob_pad_i),
    .loop_sleep_n_i(loop_sleep_n_i),
    .cfg_src_i(cfg_src_i),
    .cfg_mux_i(cfg_mux_i),
    .cfg_pad_i(cfg_pad_i),
    .cfg_diff_i(cfg_diff_i),
    .cfg_loop_used_i(cfg_loop_used_i),
    .cfg_out_en_i(cfg_out_en_i),
    .cfg_dly_i(cfg_dly_i),
    .primary_global_clk_out_o(primary_global_clk_out_o),
    .secondary1_global_clk_out_o(secondary1_global_clk_out_o),
    .secondary2_global_clk_out_o(secondary2_global_clk_out_o),
    .core1_local_clk_out_o(core1_local_clk_out_o),
    .core2_local_clk_out_o(core2_local_clk_out_o),
    .lock_o(lock_o),
    .cfg_err_o(cfg_err_o),
    .pad_user_o(pad_user_o)
);

// >>> verif/ccsos_ref_model.sv
// reference clock source standing for pads and fabric logic
`timescale 1ns/1ps
module ccsos_ref_model (
    // clock
    input wire sys_clk_i,
    // half period in cycles, zero holds the line static
    input wire [3:0] half_i,
    // reference level, handed out through ordinary input buffers
    output reg ref_o = 1'b0
);
    // start values given at declaration so only the clocked process drives them
    reg [3:0] cnt_q = 4'h0;
    // a static reference is allowed, it provokes free running
    always @(posedge sys_clk_i) begin
        if (half_i == 4'h0) begin
            cnt_q <= 4'h0;
        end else if (cnt_q + 4'h1 >= half_i) begin
            cnt_q <= 4'h0;
            ref_o <= ~ref_o;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// >>> verif/clock_source_output_select_test.sv
// self-checking bench for the clock source and output select block
`timescale 1ns/1ps
module clock_source_output_select_test;
    reg sys_clk_i, rst_i, sleep_n, diff, pair, loop;
    reg [1:0] src, mux, pad;
    reg [4:0] en;
    reg [3:0] half, adv;
    reg [19:0] dly;
    reg outside_feedback_in;
    wire ref_w, primary_global_clk_out, secondary1_global_clk_out, secondary2_global_clk_out, yb, yc, lock, err;
    wire [8:0] pad_user;
    integer err_count, check_count, cyc;
    ccsos_ref_model i_ccsos_ref_model (.sys_clk_i(sys_clk_i), .half_i(half), .ref_o(ref_w));
    // pads see the reference; the pair's negative leg is its inverse
    ccsos_top i_ccsos_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .glob_pad_i({9{ref_w}}),
        .pair_reg_n_i({3{~ref_w}}), .routed_ref_i(ref_w), .core_clk_i(ref_w),
        .outside_feedback_in_i(ref_w), .loop_sleep_n_i(sleep_n), .cfg_src_i(src),
        .cfg_mux_i(mux), .cfg_pad_i(pad), .cfg_diff_i(diff), .cfg_pair_i(pair),
        .cfg_loop_used_i(loop), .cfg_ext_fb_i(outside_feedback_in), .cfg_out_en_i(en), .cfg_dly_i(dly),
        .cfg_fb_adv_i(adv), .primary_global_clk_out_o(primary_global_clk_out), .secondary1_global_clk_out_o(secondary1_global_clk_out),
        .secondary2_global_clk_out_o(secondary2_global_clk_out), .core1_local_clk_out_o(yb),
        .core2_local_clk_out_o(yc), .lock_o(lock), .cfg_err_o(err), .pad_user_o(pad_user));
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task check(input string nm, input logic [8:0] got, input logic [8:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wrap_up;
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // config is caught only while reset is high
    task boot(input [1:0] s, m, p, input d, pr, l, input [4:0] e);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        src <= s; mux <= m; pad <= p; diff <= d; pair <= pr; loop <= l; en <= e;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    task sel(input [1:0] s, m, p, input d, pr, l, input [4:0] e, input x, input [8:0] pu);
        boot(s, m, p, d, pr, l, e);
        check("cfg_err", {8'h00, err}, {8'h00, x});
        if (!x)
            check("pad_user", pad_user, pu);
    endtask
    task t_select;
        sel(2'h0, 2'h0, 2'h0, 0, 0, 0, 5'h1f, 0, 9'h1fe);
        sel(2'h0, 2'h2, 2'h1, 0, 0, 0, 5'h01, 0, 9'h17f);
        sel(2'h0, 2'h0, 2'h0, 1, 0, 1, 5'h07, 0, 9'h1fc);
        sel(2'h0, 2'h0, 2'h0, 1, 1, 1, 5'h03, 0, 9'h1fb);
        sel(2'h1, 2'h0, 2'h0, 0, 0, 1, 5'h01, 0, 9'h1ff);
        sel(2'h2, 2'h0, 2'h0, 0, 0, 1, 5'h05, 0, 9'h1ff);
        sel(2'h0, 2'h0, 2'h0, 0, 0, 1, 5'h1e, 1, 9'h000);
        sel(2'h0, 2'h0, 2'h0, 0, 0, 1, 5'h09, 1, 9'h000);
        sel(2'h0, 2'h1, 2'h0, 0, 0, 1, 5'h01, 1, 9'h000);
        sel(2'h3, 2'h0, 2'h0, 0, 0, 0, 5'h01, 1, 9'h000);
        sel(2'h0, 2'h3, 2'h3, 0, 0, 0, 5'h01, 1, 9'h000);
    endtask
    // pad path in delay-only mode, checked edge by edge by the checker
    // all outputs share one line, so tap k lags tap 0 by k edges; twins sit 16 further
    task t_delay;
        reg [31:0] ha, hb, hc;
        half <= 4'h3;
        dly <= 20'h00020;
        boot(2'h0, 2'h0, 2'h0, 0, 0, 0, 5'h1f);
        ha = 32'h00000000;
        hb = 32'h00000000;
        hc = 32'h00000000;
        for (int i = 0; i < 60; i++) begin
            @(posedge sys_clk_i);
            #1;
            ha = {ha[30:0], primary_global_clk_out};
            hb = {hb[30:0], secondary1_global_clk_out};
            hc = {hc[30:0], secondary2_global_clk_out};
            if (i >= 40) begin
                check("glb_phase", {8'h00, secondary1_global_clk_out}, {8'h00, ha[2]});
                check("yb_twin", {8'h00, yb}, {8'h00, hb[14]});
                check("yc_twin", {8'h00, yc}, {8'h00, hc[16]});
            end
        end
    endtask
    // lock on outside or internal feedback; the advance pulls secondary-one ahead
    task t_lock(input x);
        reg p;
        half <= 4'h2;
        dly <= 20'h00030;
        adv <= 4'h2;
        outside_feedback_in <= x;
        boot(2'h0, 2'h0, 2'h1, 0, 0, 1, 5'h1f);
        for (int i = 0; i < 300 && lock !== 1'b1; i++)
            @(posedge sys_clk_i);
        #1;
        check("lock", {8'h00, lock}, 9'h001);
        // tap 3 less an advance of 2 leaves secondary-one one edge behind primary
        for (int i = 0; i < 4; i++) begin
            p = primary_global_clk_out;
            @(posedge sys_clk_i);
            #1;
            check("adv_phase", {8'h00, secondary1_global_clk_out}, {8'h00, p});
        end
        sleep_n <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        #1;
        check("sleep_outs", {3'h0, primary_global_clk_out, secondary1_global_clk_out, secondary2_global_clk_out, yb, yc, lock}, 9'h000);
        sleep_n <= 1'b1;
    endtask
    // a static reference makes the loop run free until sleep is pulled
    task t_free(output logic a);
        half <= 4'h0;
        boot(2'h0, 2'h0, 2'h0, 0, 0, 1, 5'h01);
        repeat (70) @(posedge sys_clk_i);
        #1;
        a = primary_global_clk_out;
        @(posedge sys_clk_i);
        #1;
        check("free_run", {8'h00, primary_global_clk_out}, {8'h00, ~a});
        sleep_n <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        #1;
        check("free_stop", {8'h00, primary_global_clk_out}, 9'h000);
    endtask
    // hang guard, far above the fewer than a thousand cycles needed
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            wrap_up;
        end
    end
    initial begin : main
        logic a;
        err_count = 0; check_count = 0; cyc = 0;
        rst_i = 1'b1; sleep_n = 1'b1; half = 4'h0;
        dly = 20'h00000;
        adv = 4'h0;
        outside_feedback_in = 1'b1;
        src = 2'h0; mux = 2'h0; pad = 2'h0; diff = 1'b0; pair = 1'b0; loop = 1'b0; en = 5'h01;
        repeat (2) @(posedge sys_clk_i);
        t_select;
        t_delay;
        t_lock(1'b1);
        t_lock(1'b0);
        t_free(a);
        wrap_up;
    end
endmodule
